// ==== aid_datapath.sv ====
`timescale 1ns/1ps
`include "aid_defines.svh"
// Operation
// - add immediate or memory into working register
// - add into memory, register unchanged
// - register plus memory plus carry to register
// - memory plus register plus carry to memory
// - register plus carry kept in register
// - memory plus carry written to memory
// - negated register plus memory to register
// - negated memory plus register to memory
// - register minus immediate to register
// - register minus memory to register
// - memory minus register to memory
// - register minus memory minus carry to register
// - memory minus register minus carry to memory
// - register minus carry kept in register
// - memory minus carry written to memory
// - increment memory operand
// - decrement memory operand
// - clear memory, flags untouched
// - all others update all four flags
module aid_datapath (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Command from decoder
   input  wire aid_pkg::aid_cmd_t cmd,
   // Results
   output aid_pkg::aid_mem_wr_t   mem_wr,
   output logic [7:0]             working_register,
   output aid_pkg::aid_flags_t    flags,
   output logic                   busy
);
   localparam int unsigned DATA_W = 8;

   logic [7:0]           wreg_r;
   logic [7:0]           wreg_nxt;
   aid_pkg::aid_flags_t  flg_r;
   aid_pkg::aid_flags_t  flg_nxt;
   aid_pkg::aid_mem_wr_t mw_r;
   aid_pkg::aid_mem_wr_t mw_nxt;
   aid_pkg::aid_state_t  st_r;
   aid_pkg::aid_state_t  st_nxt;

   logic [7:0] opa;
   logic [7:0] opb;
   logic       cin;
   logic       is_sub;
   logic       to_mem;
   logic       clr;
   logic       known;
   logic [7:0] res;
   logic [7:0] opb_eff;
   logic       take;
   logic       ovf;
   wire  [7:0] sum_bits;
   wire  [8:0] carry_chain;

   // Operand selection: result is opa + opb + cin, or opa - opb - cin
   always_comb begin
      opa    = wreg_r;
      opb    = 8'h00;
      cin    = 1'b0;
      is_sub = 1'b0;
      to_mem = 1'b0;
      clr    = 1'b0;
      known  = 1'b1;
      case (cmd.op)
         `AID_OP_ADD_AI: begin
            opb = cmd.imm;
         end
         `AID_OP_ADD_AM: begin
            opb = cmd.mem_data;
         end
         `AID_OP_ADD_MA: begin
            opb    = cmd.mem_data;
            to_mem = 1'b1;
         end
         `AID_OP_ADDC_AM: begin
            opb = cmd.mem_data;
            cin = flg_r.wrap;
         end
         `AID_OP_ADDC_MA: begin
            opa    = cmd.mem_data;
            opb    = wreg_r;
            cin    = flg_r.wrap;
            to_mem = 1'b1;
         end
         `AID_OP_ADDC_A: begin
            cin = flg_r.wrap;
         end
         `AID_OP_ADDC_M: begin
            opa    = cmd.mem_data;
            cin    = flg_r.wrap;
            to_mem = 1'b1;
         end
         `AID_OP_NADD_AM: begin
            opa    = cmd.mem_data;
            opb    = wreg_r;
            is_sub = 1'b1;
         end
         `AID_OP_NADD_MA: begin
            opb    = cmd.mem_data;
            is_sub = 1'b1;
            to_mem = 1'b1;
         end
         `AID_OP_SUB_AI: begin
            opb    = cmd.imm;
            is_sub = 1'b1;
         end
         `AID_OP_SUB_AM: begin
            opb    = cmd.mem_data;
            is_sub = 1'b1;
         end
         `AID_OP_SUB_MA: begin
            opa    = cmd.mem_data;
            opb    = wreg_r;
            is_sub = 1'b1;
            to_mem = 1'b1;
         end
         `AID_OP_SUBC_AM: begin
            opb    = cmd.mem_data;
            cin    = flg_r.wrap;
            is_sub = 1'b1;
         end
         `AID_OP_SUBC_MA: begin
            opa    = cmd.mem_data;
            opb    = wreg_r;
            cin    = flg_r.wrap;
            is_sub = 1'b1;
            to_mem = 1'b1;
         end
         `AID_OP_SUBC_A: begin
            cin    = flg_r.wrap;
            is_sub = 1'b1;
         end
         `AID_OP_SUBC_M: begin
            opa    = cmd.mem_data;
            cin    = flg_r.wrap;
            is_sub = 1'b1;
            to_mem = 1'b1;
         end
         `AID_OP_INC_M: begin
            opa    = cmd.mem_data;
            opb    = 8'h01;
            to_mem = 1'b1;
         end
         `AID_OP_DEC_M: begin
            opa    = cmd.mem_data;
            opb    = 8'h01;
            is_sub = 1'b1;
            to_mem = 1'b1;
         end
         `AID_OP_CLEAR_M: begin
            to_mem = 1'b1;
            clr    = 1'b1;
         end
         default: begin
            known = 1'b0;
         end
      endcase
   end

   // Subtract as add of inverted operand with inverted borrow-in
   always_comb begin
      opb_eff = is_sub ? ~opb : opb;
   end

   // Carry into every bit stays visible, so nibble carry needs no second adder
   // ripple carry
   assign carry_chain[0] = is_sub ^ cin;
   for (genvar gi = 0; gi < DATA_W; gi++) begin : g_bit
      assign sum_bits[gi]        = opa[gi] ^ opb_eff[gi] ^ carry_chain[gi];
      assign carry_chain[gi + 1] = (opa[gi] & opb_eff[gi])
                                 | (carry_chain[gi] & (opa[gi] ^ opb_eff[gi]));
   end

   always_comb begin
      res = clr ? 8'h00 : sum_bits;
      ovf = (opa[7] == opb_eff[7]) && (res[7] != opa[7]);
   end

   // Unknown codes are dropped with no effect
   always_comb begin
      take = cmd.valid && known;
   end

   // Busy marks the cycle after an accepted command
   always_comb begin
      case (st_r)
         aid_pkg::AID_IDLE: begin
            if (take) begin
               st_nxt = aid_pkg::AID_BUSY;
            end else begin
               st_nxt = aid_pkg::AID_IDLE;
            end
         end
         aid_pkg::AID_BUSY: begin
            if (take) begin
               st_nxt = aid_pkg::AID_BUSY;
            end else begin
               st_nxt = aid_pkg::AID_IDLE;
            end
         end
         default: begin
            st_nxt = aid_pkg::AID_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= aid_pkg::AID_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Memory-destination forms leave the register as it was
   // register destination
   always_comb begin
      wreg_nxt = wreg_r;
      if (take && !to_mem) begin
         wreg_nxt = res;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wreg_r <= `AID_WREG_RST;
      end else begin
         wreg_r <= wreg_nxt;
      end
   end

   // Clear leaves flags, so a pending carry survives it
   // flag update
   always_comb begin
      flg_nxt = flg_r;
      if (take && !clr) begin
         flg_nxt.zero             = (res == 8'h00);
         flg_nxt.signed_wrap_flag = ovf;
         flg_nxt.wrap             = carry_chain[DATA_W] ^ is_sub;
         flg_nxt.half_carry_flag  = carry_chain[4] ^ is_sub;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flg_r <= `AID_FLAGS_RST;
      end else begin
         flg_r <= flg_nxt;
      end
   end

   // Write strobe lasts one cycle per memory-destination command
   // memory destination
   always_comb begin
      mw_nxt = '0;
      if (take && to_mem) begin
         mw_nxt.we   = 1'b1;
         mw_nxt.data = res;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mw_r <= '0;
      end else begin
         mw_r <= mw_nxt;
      end
   end

   assign working_register = wreg_r;
   assign flags            = flg_r;
   assign mem_wr           = mw_r;
   assign busy             = (st_r == aid_pkg::AID_BUSY);
endmodule : aid_datapath

// ==== aid_datapath_assertions.sv ====
`timescale 1ns/1ps
`include "aid_defines.svh"
module aid_datapath_chk (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rst,
   // Watched ports
   input wire aid_pkg::aid_cmd_t    cmd,
   input wire aid_pkg::aid_mem_wr_t mem_wr,
   input wire logic [7:0]           working_register,
   input wire aid_pkg::aid_flags_t  flags,
   input wire logic                 busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take(logic [4:0] o);
      cmd.valid && cmd.op == o;
   endsequence
   property p_reset;
      disable iff (1'b0) rst |=> working_register == 8'h00 && flags == 4'h0 && !busy;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_add_am;
      s_take(`AID_OP_ADD_AM) |=> !mem_wr.we
         && working_register == $past(working_register) + $past(cmd.mem_data);
   endproperty
   a_add_am: assert property (p_add_am) else $error("add to register wrong");
   property p_add_ma;
      s_take(`AID_OP_ADD_MA) |=> mem_wr.we && $stable(working_register)
         && mem_wr.data == $past(working_register) + $past(cmd.mem_data);
   endproperty
   a_add_ma: assert property (p_add_ma) else $error("add to memory wrong");
   property p_sub_ai;
      s_take(`AID_OP_SUB_AI) |=> working_register == $past(working_register) - $past(cmd.imm)
         && flags.wrap == ($past(working_register) < $past(cmd.imm));
   endproperty
   a_sub_ai: assert property (p_sub_ai) else $error("subtract wrong");
   property p_inc;
      s_take(`AID_OP_INC_M) |=> mem_wr.we && mem_wr.data == $past(cmd.mem_data) + 8'h01
         && flags.zero == (mem_wr.data == 8'h00);
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong");
   property p_dec;
      s_take(`AID_OP_DEC_M) |=> mem_wr.data == $past(cmd.mem_data) - 8'h01
         && flags.wrap == ($past(cmd.mem_data) == 8'h00);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement wrong");
   property p_clear;
      s_take(`AID_OP_CLEAR_M) |=> mem_wr.we && mem_wr.data == 8'h00 && $stable(flags);
   endproperty
   a_clear: assert property (p_clear) else $error("clear wrong");
   property p_refuse;
      cmd.valid && cmd.op > `AID_OP_CLEAR_M |=> !busy && !mem_wr.we && $stable(flags);
   endproperty
   a_refuse: assert property (p_refuse) else $error("unknown op acted");
endmodule : aid_datapath_chk
bind aid_datapath aid_datapath_chk i_chk (.clk(clk), .rst(rst), .cmd(cmd), .mem_wr(mem_wr),
   .working_register(working_register), .flags(flags), .busy(busy));

// ==== aid_defines.svh ====
`ifndef AID_DEFINES_SVH
`define AID_DEFINES_SVH
// Operation codes
`define AID_OP_ADD_AI   5'h00
`define AID_OP_ADD_AM   5'h01
`define AID_OP_ADD_MA   5'h02
`define AID_OP_ADDC_AM  5'h03
`define AID_OP_ADDC_MA  5'h04
`define AID_OP_ADDC_A   5'h05
`define AID_OP_ADDC_M   5'h06
`define AID_OP_NADD_AM  5'h07
`define AID_OP_NADD_MA  5'h08
`define AID_OP_SUB_AI   5'h09
`define AID_OP_SUB_AM   5'h0A
`define AID_OP_SUB_MA   5'h0B
`define AID_OP_SUBC_AM  5'h0C
`define AID_OP_SUBC_MA  5'h0D
`define AID_OP_SUBC_A   5'h0E
`define AID_OP_SUBC_M   5'h0F
`define AID_OP_INC_M    5'h10
`define AID_OP_DEC_M    5'h11
`define AID_OP_CLEAR_M  5'h12
// Reset values
`define AID_WREG_RST    8'h00
`define AID_FLAGS_RST   4'h0
`endif

// ==== aid_mem_model.sv ====
`timescale 1ns/1ps
module aid_mem_model (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Write port and read back
   input  wire aid_pkg::aid_mem_wr_t mem_wr,
   output logic [7:0]                mem_q
);
   // One byte stands for the addressed location
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_q <= 8'h00;
      end else if (mem_wr.we) begin
         mem_q <= mem_wr.data;
      end
   end
endmodule : aid_mem_model

// ==== aid_pkg.sv ====
package aid_pkg;
   typedef struct packed {
      logic       valid;
      logic [4:0] op;
      logic [7:0] mem_data;
      logic [7:0] imm;
   } aid_cmd_t;
   typedef struct packed {
      logic signed_wrap_flag;
      logic half_carry_flag;
      logic wrap;
      logic zero;
   } aid_flags_t;
   typedef struct packed {
      logic       we;
      logic [7:0] data;
   } aid_mem_wr_t;
   typedef enum logic [1:0] {
      AID_IDLE = 2'b01,
      AID_BUSY = 2'b10
   } aid_state_t;
endpackage : aid_pkg

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "aid_defines.svh"
module testbench;
   logic                 clk;
   logic                 rst;
   aid_pkg::aid_cmd_t    cmd;
   aid_pkg::aid_mem_wr_t mem_wr;
   logic [7:0]           working_register;
   aid_pkg::aid_flags_t  flags;
   logic                 busy;
   logic [7:0]           mem_q;
   logic [7:0]           w = 8'h00;
   logic [3:0]           f = 4'h0;
   int                   fails = 0;
   int                   total_checks = 0;
   int                   cycles = 0;
   aid_datapath i_dut (.clk(clk), .rst(rst), .cmd(cmd), .mem_wr(mem_wr),
      .working_register(working_register), .flags(flags), .busy(busy));
   aid_mem_model i_mem (.clk(clk), .rst(rst), .mem_wr(mem_wr), .mem_q(mem_q));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [21:0] seen, input logic [21:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic run_op(input logic [4:0] op, input logic [7:0] imm);
      logic [7:0] x;
      logic [7:0] y;
      logic [8:0] t;
      logic       k;
      logic       s;
      logic       d;
      logic       ok;
      logic [13:0] seen_v;
      logic [13:0] exp_v;
      case (op)
         `AID_OP_ADD_AI, `AID_OP_SUB_AI: {x, y} = {w, imm};
         `AID_OP_ADDC_A, `AID_OP_SUBC_A: {x, y} = {w, 8'h00};
         `AID_OP_SUB_MA, `AID_OP_SUBC_MA, `AID_OP_NADD_AM: {x, y} = {mem_q, w};
         `AID_OP_ADDC_M, `AID_OP_SUBC_M, `AID_OP_INC_M, `AID_OP_DEC_M: {x, y} = {mem_q, 8'h00};
         default: {x, y} = {w, mem_q};
      endcase
      s = op inside {[`AID_OP_NADD_AM:`AID_OP_SUBC_M], `AID_OP_DEC_M};
      d = op inside {`AID_OP_ADD_MA, `AID_OP_ADDC_MA, `AID_OP_ADDC_M, `AID_OP_NADD_MA,
         `AID_OP_SUB_MA, `AID_OP_SUBC_MA, `AID_OP_SUBC_M, [`AID_OP_INC_M:`AID_OP_CLEAR_M]};
      k = op inside {[`AID_OP_ADDC_AM:`AID_OP_ADDC_M], [`AID_OP_SUBC_AM:`AID_OP_SUBC_M]};
      k = (k & f[1]) | (op inside {`AID_OP_INC_M, `AID_OP_DEC_M});
      t = s ? {1'b0, x} - y - k : x + y + k;
      ok = op <= `AID_OP_CLEAR_M;
      if (op == `AID_OP_CLEAR_M) t = 9'h000;
      else if (ok) f = {((x[7] ^ y[7]) == s) && (t[7] != x[7]),
         s ? {1'b0, x[3:0]} < y[3:0] + k : x[3:0] + y[3:0] + k > 5'h0F, t[8], t[7:0] == 8'h00};
      cmd = {1'b1, op, mem_q, imm};
      @(negedge clk);
      seen_v = {mem_wr.we, busy, flags, working_register};
      exp_v  = {ok & d, ok, f, (ok & !d) ? t[7:0] : w};
      check(22'(seen_v), 22'(exp_v));
      if (ok & d) check(22'(mem_wr.data), 22'(t[7:0]));
      cmd.valid = 1'b0;
      if (ok & !d) w = t[7:0];
      @(negedge clk);
   endtask : run_op
   task automatic sc_add_forms();
      for (int i = 0; i < 14; i++) run_op(5'(i % 7), 8'hC7 + 8'(i));
   endtask : sc_add_forms
   task automatic sc_sub_forms();
      for (int i = 0; i < 18; i++) run_op(5'(7 + i % 9), 8'h3A - 8'(i));
   endtask : sc_sub_forms
   task automatic sc_mem_forms();
      // Wrap both ways, then refused codes
      run_op(`AID_OP_CLEAR_M, 8'h00);
      run_op(`AID_OP_DEC_M, 8'h00);
      run_op(`AID_OP_INC_M, 8'h00);
      run_op(`AID_OP_INC_M, 8'h00);
      run_op(5'h13, 8'h00);
      run_op(5'h1F, 8'h00);
      run_op(`AID_OP_CLEAR_M, 8'h00);
   endtask : sc_mem_forms
   initial begin
      rst = 1'b1;
      cmd = '0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      sc_add_forms();
      sc_sub_forms();
      sc_mem_forms();
      give_verdict();
   end
endmodule : testbench
